// >>> design/plc_pkg.sv
// Shared constants and types for the pulse-count LED level link.
package plc_pkg;
    localparam int unsigned CLK_PERIOD_PS     = 25000;
    localparam int unsigned LATCH_TIMEOUT_US  = 500;
    localparam int unsigned OFF_TIMEOUT_US    = 500;
    localparam int unsigned LATCH_CYCLES_DEF  = (LATCH_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned OFF_CYCLES_DEF    = (OFF_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;

    localparam int          NUM_OUT   = 4;
    localparam int          CNT_W     = 6;
    localparam int          TMR_W     = 16;
    localparam int          LVL_W     = 5;
    localparam int          CUR_W     = 9;

    localparam logic [CNT_W-1:0] EDGES_DATA_MAX   = 6'h20;
    localparam logic [CNT_W-1:0] EDGES_ADDR_BOTH  = 6'h21;
    localparam logic [CNT_W-1:0] EDGES_ADDR_A     = 6'h22;
    localparam logic [CNT_W-1:0] EDGES_ADDR_B     = 6'h23;
    localparam logic [CNT_W-1:0] CNT_SAT          = 6'h3f;
    localparam logic [TMR_W-1:0] TMR_SAT          = 16'hffff;

    localparam logic [1:0]       ADDR_BOTH        = 2'h0;
    localparam logic [1:0]       ADDR_GROUP_A     = 2'h1;
    localparam logic [1:0]       ADDR_GROUP_B     = 2'h2;
    localparam logic [LVL_W-1:0] LEVEL_RESET      = 5'h00;
    localparam int               GROUP_B_OUT      = 3;

    // Nominal output current per stored level, in units of 0.1 mA.
    localparam logic [CUR_W-1:0] CURRENT_TABLE [32] = '{
        9'h000, 9'h001, 9'h002, 9'h004, 9'h005, 9'h007, 9'h00b, 9'h012,
        9'h014, 9'h016, 9'h019, 9'h01c, 9'h020, 9'h023, 9'h028, 9'h02d,
        9'h033, 9'h038, 9'h03c, 9'h046, 9'h050, 9'h05a, 9'h064, 9'h078,
        9'h082, 9'h096, 9'h0aa, 9'h0be, 9'h0d2, 9'h0f0, 9'h10e, 9'h12c};

    typedef enum logic [1:0] {
        ST_SHUT   = 2'b01,
        ST_ACTIVE = 2'b10
    } plc_state_t;

    typedef struct packed {
        logic             enable;
        logic             load_switch;
        logic [CUR_W-1:0] current;
    } plc_drive_t;

    typedef struct packed {
        plc_state_t                state;
        logic                      pin_prev;
        logic [CNT_W-1:0]          count;
        logic [TMR_W-1:0]          timer;
        logic [1:0]                addr;
        logic [LVL_W-1:0]          lvl_a;
        logic [LVL_W-1:0]          lvl_b;
        plc_drive_t [NUM_OUT-1:0]  drive;
    } plc_core_t;
endpackage

// >>> design/plc_sync.sv
// Two-flop synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module plc_sync
    import plc_pkg::*;
#(
    parameter int W = 1
)
(
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } plc_sync_t;

    plc_sync_t s_q;
    plc_sync_t s_d;

    always_comb
    begin
        s_d.meta   = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;
endmodule

// >>> design/plc_level_map.sv
// Maps a stored current level to its nominal output current.
`timescale 1ns/1ps
module plc_level_map
    import plc_pkg::*;
(
    input  wire logic [LVL_W-1:0] level,
    output logic      [CUR_W-1:0] current
);
    always_comb
    begin
        current = CURRENT_TABLE[level];
    end
endmodule

// >>> design/plc_link_top.sv
// Pulse-count single-wire receiver and LED level registers.
`timescale 1ns/1ps
module plc_link_top
    import plc_pkg::*;
#(
    parameter int unsigned LATCH_CYCLES = LATCH_CYCLES_DEF,
    parameter int unsigned OFF_CYCLES   = OFF_CYCLES_DEF
)
(
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic               en_set,
    input  wire logic [NUM_OUT-1:0] vin_above_load,
    output plc_drive_t              led_output_one,
    output plc_drive_t              led_output_two,
    output plc_drive_t              led_output_three,
    output plc_drive_t              led_output_four,
    output logic      [LVL_W-1:0]   group_a_current_level,
    output logic      [LVL_W-1:0]   group_b_current_level,
    output logic                    device_enabled
);
    localparam logic [TMR_W-1:0] LATCH_LAST = TMR_W'(LATCH_CYCLES - 1);
    localparam logic [TMR_W-1:0] OFF_LAST   = TMR_W'(OFF_CYCLES - 1);

    plc_core_t                s_q;
    plc_core_t                s_d;
    logic                     pin_s;
    logic [NUM_OUT-1:0]       vin_s;
    logic [CUR_W-1:0]         cur_a;
    logic [CUR_W-1:0]         cur_b;
    plc_drive_t [NUM_OUT-1:0] drive_d;
    logic                     rise;
    logic                     lat_fire;
    logic                     off_fire;
    logic                     active;

    // Pins come from outside the clock domain.
    plc_sync #(.W(NUM_OUT + 1)) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({vin_above_load, en_set}),
        .sync_out ({vin_s, pin_s})
    );

    plc_level_map u_map_a (
        .level   (s_q.lvl_a),
        .current (cur_a)
    );

    plc_level_map u_map_b (
        .level   (s_q.lvl_b),
        .current (cur_b)
    );

    assign active   = (s_q.state == ST_ACTIVE);
    assign rise     = pin_s & ~s_q.pin_prev;
    // A burst latches once the line has stood high for the latch time.
    assign lat_fire = active && pin_s && s_q.pin_prev && (s_q.count != '0)
                      && (s_q.timer == LATCH_LAST);
    assign off_fire = active && !pin_s && !s_q.pin_prev
                      && (s_q.timer == OFF_LAST);

    // Per-output drive: group A feeds outputs one to three, group B output four.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_OUT; gi++)
        begin : g_out
            always_comb
            begin
                drive_d[gi].enable      = active;
                drive_d[gi].load_switch = active & vin_s[gi];
                if (!active)
                begin
                    drive_d[gi].current = '0;
                end
                else if (gi == GROUP_B_OUT)
                begin
                    drive_d[gi].current = cur_b;
                end
                else
                begin
                    drive_d[gi].current = cur_a;
                end
            end
        end
    endgenerate

    always_comb
    begin
        s_d          = s_q;
        s_d.pin_prev = pin_s;
        s_d.drive    = drive_d;
        // The timer measures how long the line has held its present level.
        if (pin_s != s_q.pin_prev)
        begin
            s_d.timer = '0;
        end
        else if (s_q.timer != TMR_SAT)
        begin
            s_d.timer = s_q.timer + 16'h0001;
        end
        if (rise)
        begin
            s_d.state = ST_ACTIVE;
            if (s_q.count != CNT_SAT)
            begin
                s_d.count = s_q.count + 6'h01;
            end
        end
        if (lat_fire)
        begin
            s_d.count = '0;
            if (s_q.count <= EDGES_DATA_MAX)
            begin
                // Data code 1..32 is stored as code minus one.
                case (s_q.addr)
                    ADDR_BOTH:
                    begin
                        s_d.lvl_a = LVL_W'(s_q.count - 6'h01);
                        s_d.lvl_b = LVL_W'(s_q.count - 6'h01);
                    end
                    ADDR_GROUP_A:
                    begin
                        s_d.lvl_a = LVL_W'(s_q.count - 6'h01);
                    end
                    ADDR_GROUP_B:
                    begin
                        s_d.lvl_b = LVL_W'(s_q.count - 6'h01);
                    end
                    default:
                    begin
                        s_d.lvl_a = s_q.lvl_a;
                    end
                endcase
            end
            else if (s_q.count == EDGES_ADDR_BOTH)
            begin
                s_d.addr = ADDR_BOTH;
            end
            else if (s_q.count == EDGES_ADDR_A)
            begin
                s_d.addr = ADDR_GROUP_A;
            end
            else if (s_q.count == EDGES_ADDR_B)
            begin
                s_d.addr = ADDR_GROUP_B;
            end
            else
            begin
                // Any other count is dropped and the address is kept.
                s_d.addr = s_q.addr;
            end
        end
        if (off_fire)
        begin
            s_d.state = ST_SHUT;
            s_d.count = '0;
            s_d.addr  = ADDR_BOTH;
            s_d.lvl_a = LEVEL_RESET;
            s_d.lvl_b = LEVEL_RESET;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_q       <= '0;
            s_q.state <= ST_SHUT;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign led_output_one        = s_q.drive[0];
    assign led_output_two        = s_q.drive[1];
    assign led_output_three      = s_q.drive[2];
    assign led_output_four       = s_q.drive[3];
    assign group_a_current_level = s_q.lvl_a;
    assign group_b_current_level = s_q.lvl_b;
    assign device_enabled        = s_q.drive[0].enable;

    // Checks on the receiver.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_data_fire;
        lat_fire && (s_q.count >= 6'h01) && (s_q.count <= EDGES_DATA_MAX);
    endsequence

    sequence s_bad_fire;
        lat_fire && (s_q.count > EDGES_ADDR_B);
    endsequence

    sequence s_wake;
        rise && !active;
    endsequence

    a_both_loaded: assert property (
        s_data_fire and (s_q.addr == ADDR_BOTH) |=>
        (s_q.lvl_a == LVL_W'($past(s_q.count) - 6'h01)) && (s_q.lvl_b == s_q.lvl_a))
        else $error("Address 0 data did not load both levels.");

    a_group_a_only: assert property (
        s_data_fire and (s_q.addr == ADDR_GROUP_A) |=>
        (s_q.lvl_a == LVL_W'($past(s_q.count) - 6'h01)) && $stable(s_q.lvl_b))
        else $error("Address 1 data did not load group A alone.");

    a_group_b_only: assert property (
        s_data_fire and (s_q.addr == ADDR_GROUP_B) |=>
        (s_q.lvl_b == LVL_W'($past(s_q.count) - 6'h01)) && $stable(s_q.lvl_a))
        else $error("Address 2 data did not load group B alone.");

    a_edge_count: assert property (
        rise && !lat_fire && !off_fire && (s_q.count != CNT_SAT) |=>
        s_q.count == $past(s_q.count) + 6'h01)
        else $error("Rising edge was not counted.");

    a_latch_time: assert property (
        lat_fire |-> pin_s && (s_q.timer == LATCH_LAST) ##1 (s_q.count == '0))
        else $error("Latch fired at the wrong time.");

    a_addr_decode: assert property (
        lat_fire && (s_q.count >= EDGES_ADDR_BOTH) && (s_q.count <= EDGES_ADDR_B) |=>
        (s_q.addr == 2'($past(s_q.count) - EDGES_ADDR_BOTH)) && $stable(s_q.lvl_a))
        else $error("Address burst decoded wrongly.");

    a_bad_ignored: assert property (
        s_bad_fire |=> $stable(s_q.lvl_a) && $stable(s_q.lvl_b) && $stable(s_q.addr))
        else $error("Out of range burst changed state.");

    a_off_timeout: assert property (
        off_fire |=> (s_q.state == ST_SHUT) ##1 !led_output_four.enable)
        else $error("Off timeout did not shut down.");

    a_shut_clear: assert property (
        (s_q.state == ST_SHUT) |-> (s_q.lvl_a == '0) && (s_q.lvl_b == '0) && (s_q.addr == '0))
        else $error("Shutdown left state uncleared.");

    a_switch_mode: assert property (
        active && !off_fire |=> led_output_two.load_switch == $past(vin_s[1]))
        else $error("Load switch mode does not follow supply sense.");

    a_level_map: assert property (
        active && !off_fire |=> led_output_four.current == CURRENT_TABLE[$past(s_q.lvl_b)])
        else $error("Output current does not follow level table.");

    a_addr_kept: assert property (
        s_data_fire |=> $stable(s_q.addr))
        else $error("Data burst changed the latched address.");

    a_wake_addr: assert property (
        s_wake |=> (s_q.addr == ADDR_BOTH) && active)
        else $error("Wake edge did not start at address 0.");

    a_data_range: assert property (
        lat_fire && (s_q.count > EDGES_DATA_MAX) |=> $stable(s_q.lvl_a) && $stable(s_q.lvl_b))
        else $error("A burst above 32 edges loaded a level.");

    a_enable_on: assert property (
        s_wake |=> active ##1 (device_enabled && led_output_four.enable))
        else $error("Outputs were not enabled after wake.");

    a_no_early_latch: assert property (
        active && pin_s && s_q.pin_prev && (s_q.timer < LATCH_LAST) |=> $stable(s_q.count))
        else $error("Burst latched before the latch time.");

    a_group_a_map: assert property (
        active |=> (led_output_one.current == CURRENT_TABLE[$past(s_q.lvl_a)]) &&
        (led_output_two.current == led_output_one.current) &&
        (led_output_three.current == led_output_one.current))
        else $error("Group A outputs do not follow the level table.");

    a_shut_outputs: assert property (
        !active |=> !device_enabled && !led_output_one.load_switch &&
        (led_output_one.current == '0) && (led_output_four.current == '0))
        else $error("Outputs stayed on while shut down.");

    a_count_sat: assert property (
        rise && (s_q.count == CNT_SAT) |=> (s_q.count == CNT_SAT))
        else $error("Edge count left saturation.");

    a_off_wait: assert property (
        active && !pin_s && !s_q.pin_prev && (s_q.timer < OFF_LAST) |=> active)
        else $error("Shut down before the off time.");
endmodule

// >>> verif/plc_host.sv
// Host model that drives the single control line with edge bursts.
`timescale 1ns/1ps
module plc_host
    import plc_pkg::*;
#(
    parameter int LAT = 40,
    parameter int OFF = 60
)
(
    input  wire logic clock,
    output logic      en_set
);
    initial en_set = 1'b0;

    // Sends n rising edges, then holds the line high past the latch timeout.
    task automatic burst(input int n);
        repeat (n)
        begin
            @(posedge clock);
            en_set <= 1'b0;
            repeat (2) @(posedge clock);
            en_set <= 1'b1;
            @(posedge clock);
        end
        repeat (LAT + 8) @(posedge clock);
    endtask

    // Holds the line low past the off timeout.
    task automatic shut();
        @(posedge clock);
        en_set <= 1'b0;
        repeat (OFF + 8) @(posedge clock);
    endtask
endmodule

// >>> verif/pulse_count_led_level_link_test.sv
// Self-checking bench for the pulse-count LED level link.
`timescale 1ns/1ps
module pulse_count_led_level_link_test;
    import plc_pkg::*;

    localparam int LAT = 40;
    localparam int OFF = 60;

    typedef struct {
        int ad;
        int dt;
        int ea;
        int eb;
    } plc_row_t;

    logic               clock;
    logic               rst;
    logic               en_set;
    logic [NUM_OUT-1:0] vin_above_load;
    plc_drive_t         led_one;
    plc_drive_t         led_two;
    plc_drive_t         led_three;
    plc_drive_t         led_four;
    logic [LVL_W-1:0]   lvl_a;
    logic [LVL_W-1:0]   lvl_b;
    logic               device_enabled;
    int                 n_fail;
    int                 samples_checked;

    // Address burst (0 = none), data burst, expected stored levels.
    plc_row_t rows [8] = '{'{0, 5, 4, 4}, '{34, 32, 31, 4}, '{35, 1, 31, 0},
        '{0, 10, 31, 9}, '{33, 7, 6, 6}, '{0, 36, 6, 6}, '{0, 2, 1, 1},
        '{34, 0, 1, 1}};

    plc_link_top #(
        .LATCH_CYCLES (LAT),
        .OFF_CYCLES   (OFF)
    ) plc_link_top_i (
        .clock                 (clock),
        .rst                   (rst),
        .en_set                (en_set),
        .vin_above_load        (vin_above_load),
        .led_output_one        (led_one),
        .led_output_two        (led_two),
        .led_output_three      (led_three),
        .led_output_four       (led_four),
        .group_a_current_level (lvl_a),
        .group_b_current_level (lvl_b),
        .device_enabled        (device_enabled)
    );

    plc_host #(
        .LAT (LAT),
        .OFF (OFF)
    ) plc_host_i (
        .clock  (clock),
        .en_set (en_set)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_all(input logic [4:0] ea, input logic [4:0] eb, input logic en);
        chk(16'(lvl_a), 16'(ea));
        chk(16'(lvl_b), 16'(eb));
        chk(16'(led_one.current), 16'(CURRENT_TABLE[ea]));
        chk(16'(led_two.current), 16'(CURRENT_TABLE[ea]));
        chk(16'(led_three.current), 16'(CURRENT_TABLE[ea]));
        chk(16'(led_four.current), 16'(CURRENT_TABLE[eb]));
        chk(16'({led_one.enable, led_two.enable, led_three.enable, led_four.enable,
            device_enabled}), en ? 16'h001f : 16'h0000);
        chk(16'({led_four.load_switch, led_three.load_switch, led_two.load_switch,
            led_one.load_switch}), en ? 16'(vin_above_load) : 16'h0000);
    endtask

    task automatic end_sim();
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        end_sim();
    end

    initial
    begin
        n_fail = 0;
        samples_checked = 0;
        rst = 1'b1;
        vin_above_load = 4'h0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check_all(5'h00, 5'h00, 1'b0);
        foreach (rows[i])
        begin
            @(posedge clock);
            vin_above_load <= 4'(i + 5);
            if (rows[i].ad != 0)
                plc_host_i.burst(rows[i].ad);
            plc_host_i.burst(rows[i].dt);
            check_all(5'(rows[i].ea), 5'(rows[i].eb), 1'b1);
        end
        plc_host_i.shut();
        check_all(5'h00, 5'h00, 1'b0);
        plc_host_i.burst(4);
        check_all(5'h03, 5'h03, 1'b1);
        plc_host_i.burst(35);
        plc_host_i.burst(9);
        check_all(5'h03, 5'h08, 1'b1);
        plc_host_i.burst(37);
        plc_host_i.burst(2);
        check_all(5'h03, 5'h01, 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        check_all(5'h00, 5'h00, 1'b0);
        plc_host_i.shut();
        rst <= 1'b0;
        @(posedge clock);
        check_all(5'h00, 5'h00, 1'b0);
        plc_host_i.burst(6);
        check_all(5'h05, 5'h05, 1'b1);
        plc_host_i.burst(66);
        check_all(5'h05, 5'h05, 1'b1);
        end_sim();
    end
endmodule
